/* rtl/crs_core.sv */
// cpu register set with operand formatting, alignment checks and exception stacking
// Operation
// RULE1 - sixteen general, three control, four system registers
// RULE2 - register zero is the index register
// RULE3 - register fifteen stacks status and pc
// RULE4 - global base feeds global indexed addressing
// RULE5 - vector base locates exception vectors
// RULE6 - mac pair holds multiply results
// RULE7 - return address register and fetch pc
// RULE8 - reset: mask bits ones, vector base zero
// RULE9 - reset loads stack and pc from table
// RULE10 - byte and word loads sign-extended
// RULE11 - misaligned word or longword gives address error
// RULE12 - byte access never checked for alignment
// RULE13 - stack area longword aligned only
// RULE14 - move, add, compare immediates sign-extended
// RULE15 - logic immediates zero-extended
// RULE16 - long immediates come through pc-relative loads
// RULE17 - registers hold until changed
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
module crs_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [crs_pkg::CRS_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] rd_sel_a,
    input wire logic [3:0] rd_sel_b,
    output logic [31:0] opr_a,
    output logic [31:0] opr_b,
    output logic [31:0] index_value,
    output logic [31:0] gbr_index_addr,
    output logic [31:0] stack_ptr,
    output logic [31:0] status_word,
    output logic [31:0] gbr_value,
    output logic [31:0] vbr_value,
    output logic [31:0] mac_high,
    output logic [31:0] mac_low,
    output logic [31:0] return_addr,
    output logic [31:0] pc_value,
    input wire crs_pkg::crs_wb_t wb,
    input wire crs_pkg::crs_ctl_t ctl_wr,
    input wire crs_pkg::crs_mac_t mac_wr,
    input wire logic [7:0] imm_in,
    input wire logic imm_zext,
    output logic [31:0] imm_out,
    input wire crs_pkg::crs_acc_t acc,
    output logic addr_err,
    input wire logic exc_req,
    input wire logic [7:0] exc_vector,
    output logic busy,
    output crs_pkg::crs_mem_t mem_req,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    output logic irq
);
    import crs_pkg::*;

    typedef enum logic [2:0] {ST_VEC_PC, ST_VEC_SP, ST_RUN, ST_PUSH_SR, ST_PUSH_PC, ST_VEC_EXC} crs_state_t;

    logic [31:0] gpr [CRS_NGPR];
    logic [31:0] sr;
    logic [31:0] global_base_pointer;
    logic [31:0] vector_table_base;
    logic [31:0] mac_result_high;
    logic [31:0] mac_result_low;
    logic [31:0] pr;
    logic [31:0] pc;
    logic [CRS_NEV-1:0] ev_status;
    logic [CRS_NEV-1:0] ev_mask;
    logic [7:0] exc_vec;
    crs_state_t state;
    crs_state_t next_state;
    crs_mem_t next_mem;
    logic sp_load;
    logic [31:0] sp_data;
    logic pc_load;
    logic [31:0] pc_data;
    logic ev_vec;
    logic ev_exc;
    logic ev_stack_fsm;

    // port decode
    wire port_gpr = (reg_addr[7:6] == 2'b00) && (reg_addr[1:0] == 2'b00);
    wire [3:0] port_idx = reg_addr[5:2];
    wire wr_sr = reg_wr && (reg_addr == CRS_OFS_SR);
    wire wr_gbr = reg_wr && (reg_addr == CRS_OFS_GBR);
    wire wr_vbr = reg_wr && (reg_addr == CRS_OFS_VBR);
    wire wr_mac_result_high = reg_wr && (reg_addr == CRS_OFS_MAC_RESULT_HIGH);
    wire wr_mac_result_low = reg_wr && (reg_addr == CRS_OFS_MAC_RESULT_LOW);
    wire wr_pr = reg_wr && (reg_addr == CRS_OFS_PR);
    wire wr_mask = reg_wr && (reg_addr == CRS_OFS_IRQ_MASK);
    wire rd_stat = reg_rd && (reg_addr == CRS_OFS_IRQ_STAT);

    // datapath control writes
    wire dp_sr = ctl_wr.valid && (ctl_wr.sel == CRS_C_SR);
    wire dp_gbr = ctl_wr.valid && (ctl_wr.sel == CRS_C_GBR);
    wire dp_vbr = ctl_wr.valid && (ctl_wr.sel == CRS_C_VBR);
    wire dp_mac_result_high = ctl_wr.valid && (ctl_wr.sel == CRS_C_MAC_RESULT_HIGH);
    wire dp_mac_result_low = ctl_wr.valid && (ctl_wr.sel == CRS_C_MAC_RESULT_LOW);
    wire dp_pr = ctl_wr.valid && (ctl_wr.sel == CRS_C_PR);
    wire dp_pc = ctl_wr.valid && (ctl_wr.sel == CRS_C_PC);

    // writeback formatting
    wire [31:0] mem_fmt = (wb.size == CRS_SZ_BYTE) ? {{24{wb.data[7]}}, wb.data[7:0]} :
                          (wb.size == CRS_SZ_WORD) ? {{16{wb.data[15]}}, wb.data[15:0]} :
                          wb.data; // RULE10
    wire [31:0] imm_sext = {{24{wb.data[7]}}, wb.data[7:0]}; // RULE14
    wire [31:0] imm_zext_wb = {24'h000000, wb.data[7:0]}; // RULE15
    wire [31:0] wb_value = (wb.src == CRS_WB_MEM) ? mem_fmt :
                           (wb.src == CRS_WB_IMM_SEXT) ? imm_sext :
                           (wb.src == CRS_WB_IMM_ZEXT) ? imm_zext_wb :
                           wb.data;
    wire [31:0] imm_fmt = imm_zext ? {24'h000000, imm_in} : {{24{imm_in[7]}}, imm_in}; // RULE14 RULE15

    // alignment checks; bytes pass at any address unless marked as stack accesses
    wire acc_word_bad = (acc.size == CRS_SZ_WORD) && acc.addr[0]; // RULE11
    wire acc_long_bad = (acc.size == CRS_SZ_LONG) && (acc.addr[1:0] != 2'b00); // RULE11 RULE12
    wire acc_misalign = acc.valid && (acc_word_bad || acc_long_bad);
    wire acc_stack_bad = acc.valid && acc.stack && (acc.size != CRS_SZ_LONG); // RULE13

    // fsm memory request shape
    wire [31:0] sp_cur = gpr[CRS_STACK_REG];
    wire [31:0] sp_dec = sp_cur - CRS_LONG_BYTES; // RULE3
    wire [31:0] vec_exc_addr = vector_table_base + {22'h000000, exc_vec, 2'b00}; // RULE5
    wire push_state = (state == ST_PUSH_SR) || (state == ST_PUSH_PC);
    wire [31:0] fsm_addr = (state == ST_VEC_PC) ? vector_table_base + CRS_VEC_PC_OFS :
                           (state == ST_VEC_SP) ? vector_table_base + CRS_VEC_SP_OFS :
                           push_state ? sp_dec : vec_exc_addr;
    wire [31:0] fsm_wdata = (state == ST_PUSH_SR) ? sr : pc;
    wire issue = (state != ST_RUN) && !mem_req.valid;
    wire done = mem_req.valid && mem_ack;

    always_comb begin
        next_state = state;
        next_mem = mem_req;
        sp_load = 1'b0;
        sp_data = sp_dec;
        pc_load = 1'b0;
        pc_data = mem_rdata;
        ev_vec = 1'b0;
        ev_exc = 1'b0;
        ev_stack_fsm = 1'b0;
        if (issue) begin
            next_mem = '{valid: 1'b1, write: push_state, addr: fsm_addr, wdata: fsm_wdata};
            ev_stack_fsm = push_state && (sp_cur[1:0] != 2'b00); // RULE13
        end else if (done) begin
            next_mem.valid = 1'b0;
        end
        case (state)
            ST_VEC_PC: begin
                if (done) begin
                    pc_load = 1'b1; // RULE9
                    next_state = ST_VEC_SP;
                end
            end
            ST_VEC_SP: begin
                if (done) begin
                    sp_load = 1'b1; // RULE9
                    sp_data = mem_rdata;
                    ev_vec = 1'b1;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (exc_req) begin
                    ev_exc = 1'b1;
                    next_state = ST_PUSH_SR;
                end
            end
            ST_PUSH_SR: begin
                if (done) begin
                    sp_load = 1'b1; // RULE3
                    next_state = ST_PUSH_PC;
                end
            end
            ST_PUSH_PC: begin
                if (done) begin
                    sp_load = 1'b1; // RULE3
                    next_state = ST_VEC_EXC;
                end
            end
            ST_VEC_EXC: begin
                if (done) begin
                    pc_load = 1'b1; // RULE5
                    ev_vec = 1'b1;
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_VEC_PC;
            mem_req <= '0;
            exc_vec <= 8'h00;
        end else begin
            state <= next_state;
            mem_req <= next_mem;
            if (ev_exc) begin
                exc_vec <= exc_vector;
            end
        end
    end

    // general registers, fsm stack update beats writeback beats port
    genvar gi;
    generate
        for (gi = 0; gi < CRS_NGPR; gi++) begin : g_gpr
            wire fsm_we = sp_load && (gi == CRS_STACK_REG);
            wire wb_we = wb.valid && (wb.dest == gi);
            wire port_we = reg_wr && port_gpr && (port_idx == gi);
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    gpr[gi] <= CRS_UNDEF_RESET;
                end else if (fsm_we) begin
                    gpr[gi] <= sp_data; // RULE3
                end else if (wb_we) begin
                    gpr[gi] <= wb_value; // RULE1 RULE16
                end else if (port_we) begin
                    gpr[gi] <= reg_wdata; // RULE17
                end
            end
        end
    endgenerate

    // control and system registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sr <= CRS_SR_RESET; // RULE8
            global_base_pointer <= CRS_UNDEF_RESET;
            vector_table_base <= CRS_VBR_RESET; // RULE8
            pr <= CRS_UNDEF_RESET;
            pc <= CRS_UNDEF_RESET;
        end else begin
            if (dp_sr) begin
                sr <= ctl_wr.data & CRS_SR_WMASK;
            end else if (wr_sr) begin
                sr <= reg_wdata & CRS_SR_WMASK; // RULE8
            end
            if (dp_gbr || wr_gbr) begin
                global_base_pointer <= dp_gbr ? ctl_wr.data : reg_wdata; // RULE4
            end
            if (dp_vbr || wr_vbr) begin
                vector_table_base <= dp_vbr ? ctl_wr.data : reg_wdata; // RULE5
            end
            if (dp_pr || wr_pr) begin
                pr <= dp_pr ? ctl_wr.data : reg_wdata; // RULE7
            end
            // pc is read-only from the port
            if (pc_load) begin
                pc <= pc_data;
            end else if (dp_pc) begin
                pc <= ctl_wr.data; // RULE7
            end
        end
    end

    // mac pair; a pair write beats single writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mac_result_high <= CRS_UNDEF_RESET;
            mac_result_low <= CRS_UNDEF_RESET;
        end else begin
            if (mac_wr.valid) begin
                mac_result_high <= mac_wr.high; // RULE6
                mac_result_low <= mac_wr.low; // RULE6
            end else begin
                if (dp_mac_result_high || wr_mac_result_high) begin
                    mac_result_high <= dp_mac_result_high ? ctl_wr.data : reg_wdata; // RULE17
                end
                if (dp_mac_result_low || wr_mac_result_low) begin
                    mac_result_low <= dp_mac_result_low ? ctl_wr.data : reg_wdata; // RULE17
                end
            end
        end
    end

    // interrupt status: set wins over read clear
    wire [CRS_NEV-1:0] ev_set = {ev_vec, ev_exc, acc_stack_bad | ev_stack_fsm, acc_misalign};
    wire [CRS_NEV-1:0] ev_clr = rd_stat ? ev_status : '0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev_status <= '0;
            ev_mask <= CRS_MASK_RESET;
            irq <= 1'b0;
        end else begin
            ev_status <= (ev_status & ~ev_clr) | ev_set;
            if (wr_mask) begin
                ev_mask <= reg_wdata[CRS_NEV-1:0];
            end
            irq <= |(((ev_status & ~ev_clr) | ev_set) & (wr_mask ? reg_wdata[CRS_NEV-1:0] : ev_mask));
        end
    end

    // read mux; unmapped offsets read zero
    wire [31:0] rd_mux = port_gpr ? gpr[port_idx] :
                         (reg_addr == CRS_OFS_SR) ? sr :
                         (reg_addr == CRS_OFS_GBR) ? global_base_pointer :
                         (reg_addr == CRS_OFS_VBR) ? vector_table_base :
                         (reg_addr == CRS_OFS_MAC_RESULT_HIGH) ? mac_result_high :
                         (reg_addr == CRS_OFS_MAC_RESULT_LOW) ? mac_result_low :
                         (reg_addr == CRS_OFS_PR) ? pr :
                         (reg_addr == CRS_OFS_PC) ? pc :
                         (reg_addr == CRS_OFS_IRQ_STAT) ? {28'h0000000, ev_status} :
                         (reg_addr == CRS_OFS_IRQ_MASK) ? {28'h0000000, ev_mask} :
                         32'h00000000;

    // registered outputs toward the datapath
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
            opr_a <= 32'h00000000;
            opr_b <= 32'h00000000;
            gbr_index_addr <= 32'h00000000;
            imm_out <= 32'h00000000;
            addr_err <= 1'b0;
            busy <= 1'b1;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
            opr_a <= gpr[rd_sel_a]; // RULE1
            opr_b <= gpr[rd_sel_b];
            gbr_index_addr <= global_base_pointer + gpr[CRS_INDEX_REG]; // RULE2 RULE4
            imm_out <= imm_fmt;
            addr_err <= acc_misalign | acc_stack_bad; // RULE11 RULE13
            busy <= next_state != ST_RUN;
        end
    end

    // plain register views, all flop outputs
    assign index_value = gpr[CRS_INDEX_REG]; // RULE2
    assign stack_ptr = gpr[CRS_STACK_REG];
    assign status_word = sr;
    assign gbr_value = global_base_pointer;
    assign vbr_value = vector_table_base;
    assign mac_high = mac_result_high;
    assign mac_low = mac_result_low;
    assign return_addr = pr;
    assign pc_value = pc;
endmodule : crs_core

/* rtl/crs_pkg.sv */
// constants and carrier types of the cpu register set
package crs_pkg;
    localparam int CRS_XLEN = 32;
    localparam int CRS_NGPR = 16;
    localparam int CRS_AW = 8;
    localparam logic [3:0] CRS_INDEX_REG = 4'h0;
    localparam logic [3:0] CRS_STACK_REG = 4'hF;
    // status word layout
    localparam int CRS_SR_T = 0;
    localparam int CRS_SR_S = 1;
    localparam int CRS_SR_IMASK_LSB = 4;
    localparam int CRS_SR_IMASK_W = 4;
    localparam logic [31:0] CRS_SR_WMASK = 32'h000003F3;
    localparam logic [31:0] CRS_SR_RESET = 32'h000000F0;
    localparam logic [31:0] CRS_VBR_RESET = 32'h00000000;
    localparam logic [31:0] CRS_UNDEF_RESET = 32'h00000000;
    // vector table entries, relative to the vector base
    localparam logic [31:0] CRS_VEC_PC_OFS = 32'h00000000;
    localparam logic [31:0] CRS_VEC_SP_OFS = 32'h00000004;
    localparam logic [31:0] CRS_LONG_BYTES = 32'h00000004;
    // register port map
    localparam logic [7:0] CRS_OFS_GPR0 = 8'h00;
    localparam logic [7:0] CRS_OFS_SR = 8'h40;
    localparam logic [7:0] CRS_OFS_GBR = 8'h44;
    localparam logic [7:0] CRS_OFS_VBR = 8'h48;
    localparam logic [7:0] CRS_OFS_MAC_RESULT_HIGH = 8'h4C;
    localparam logic [7:0] CRS_OFS_MAC_RESULT_LOW = 8'h50;
    localparam logic [7:0] CRS_OFS_PR = 8'h54;
    localparam logic [7:0] CRS_OFS_PC = 8'h58;
    localparam logic [7:0] CRS_OFS_IRQ_STAT = 8'h60;
    localparam logic [7:0] CRS_OFS_IRQ_MASK = 8'h64;
    // event bits of status and mask
    localparam int CRS_NEV = 4;
    localparam int CRS_EV_ADDR_ERR = 0;
    localparam int CRS_EV_STACK_ERR = 1;
    localparam int CRS_EV_EXC_ENTRY = 2;
    localparam int CRS_EV_VEC_LOAD = 3;
    localparam logic [3:0] CRS_MASK_RESET = 4'h0;

    typedef enum logic [1:0] {CRS_SZ_BYTE, CRS_SZ_WORD, CRS_SZ_LONG} crs_size_t;
    typedef enum logic [1:0] {CRS_WB_ALU, CRS_WB_MEM, CRS_WB_IMM_SEXT, CRS_WB_IMM_ZEXT} crs_wsrc_t;
    typedef enum logic [2:0] {CRS_C_SR, CRS_C_GBR, CRS_C_VBR, CRS_C_MAC_RESULT_HIGH, CRS_C_MAC_RESULT_LOW, CRS_C_PR, CRS_C_PC} crs_creg_t;

    typedef struct packed {
        logic valid;
        logic [3:0] dest;
        crs_wsrc_t src;
        crs_size_t size;
        logic [31:0] data;
    } crs_wb_t;

    typedef struct packed {
        logic valid;
        crs_creg_t sel;
        logic [31:0] data;
    } crs_ctl_t;

    typedef struct packed {
        logic valid;
        logic [31:0] high;
        logic [31:0] low;
    } crs_mac_t;

    typedef struct packed {
        logic valid;
        logic stack;
        crs_size_t size;
        logic [31:0] addr;
    } crs_acc_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } crs_mem_t;
endpackage : crs_pkg

/* testbench/crs_core_props.sv */
// concurrent checks on the register set ports
`timescale 1ns/100ps
module crs_core_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] imm_in,
    input wire logic imm_zext,
    input wire logic [31:0] imm_out,
    input wire crs_pkg::crs_acc_t acc,
    input wire logic addr_err,
    input wire logic [31:0] gbr_index_addr,
    input wire logic [31:0] gbr_value,
    input wire logic [31:0] index_value,
    input wire logic [31:0] vbr_value,
    input wire logic [31:0] status_word,
    input wire crs_pkg::crs_mem_t mem_req,
    input wire logic mem_ack
);
    import crs_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire bad_acc = acc.valid && ((acc.size == CRS_SZ_WORD && acc.addr[0]) ||
        (acc.size == CRS_SZ_LONG && acc.addr[1:0] != 2'h0) || (acc.stack && acc.size != CRS_SZ_LONG));
    AST_ACC_BAD: assert property (bad_acc |=> addr_err)
        else $error("misaligned access not flagged");
    AST_BYTE_OK: assert property (acc.valid && !acc.stack && acc.size == CRS_SZ_BYTE |=> !addr_err)
        else $error("byte access flagged");
    // guard on reset history: the first edge still shows cleared flops
    AST_IMM_EXT: assert property (!$past(rst) |-> imm_out == ($past(imm_zext) ? {24'h0, $past(imm_in)} :
        {{24{$past(imm_in[7])}}, $past(imm_in)})) else $error("immediate extension wrong");
    AST_IDX_SUM: assert property (!$past(rst) |-> gbr_index_addr == $past(gbr_value) + $past(index_value))
        else $error("indexed global address wrong");
    AST_RD_IDLE: assert property (!$past(rst) && !$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");
    AST_RST_VAL: assert property ($fell(rst) |-> vbr_value == CRS_VBR_RESET && status_word[7:4] == 4'hF &&
        (status_word & ~CRS_SR_WMASK) == 32'h00000000) else $error("reset values wrong");
    AST_RST_FETCH: assert property ($fell(rst) |=> mem_req.valid && !mem_req.write &&
        mem_req.addr == vbr_value + CRS_VEC_PC_OFS) else $error("no vector fetch after reset");
    AST_MEM_HOLD: assert property (mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req.addr))
        else $error("memory request dropped early");
    cover property (bad_acc);
    cover property (mem_req.valid && mem_req.write && mem_ack);
    cover property (reg_rd ##1 reg_rdata != 32'h00000000);
endmodule : crs_core_props

bind crs_core crs_core_props i_props (.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .imm_in(imm_in), .imm_zext(imm_zext), .imm_out(imm_out), .acc(acc), .addr_err(addr_err),
    .gbr_index_addr(gbr_index_addr), .gbr_value(gbr_value), .index_value(index_value),
    .vbr_value(vbr_value), .status_word(status_word), .mem_req(mem_req), .mem_ack(mem_ack));

/* testbench/crs_mem_model.sv */
// memory side model: vector table and stack writes
`timescale 1ns/100ps
module crs_mem_model #(
    parameter logic [31:0] BOOT_ENTRY = 32'h00001000,
    parameter logic [31:0] BOOT_STACK = 32'h0000F000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire crs_pkg::crs_mem_t mem_req,
    input wire logic [3:0] slow,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    import crs_pkg::*;
    logic [31:0] wa [2];
    logic [31:0] wd [2];
    int nw;
    int waitc;
    function automatic logic [31:0] table_word(input logic [31:0] a);
        if (a == CRS_VEC_PC_OFS) return BOOT_ENTRY;
        if (a == CRS_VEC_SP_OFS) return BOOT_STACK;
        return {16'hE000, a[15:0]};
    endfunction : table_word
    // idle data toggles so a stale read never looks valid
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'hFFFFFFFF;
            waitc <= 0;
            nw <= 0;
        end else if (mem_ack || !mem_req.valid) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (waitc < int'(slow)) begin
            waitc <= waitc + 1;
        end else begin
            mem_ack <= 1'b1;
            waitc <= 0;
            mem_rdata <= mem_req.write ? ~mem_rdata : table_word(mem_req.addr);
            if (mem_req.write && nw < 2) begin
                wa[nw] <= mem_req.addr;
                wd[nw] <= mem_req.wdata;
                nw <= nw + 1;
            end
        end
    end
endmodule : crs_mem_model

/* testbench/crs_core_tb.sv */
// self-checking bench of the cpu register set
`timescale 1ns/100ps
module crs_core_tb;
    import crs_pkg::*;
    localparam logic [31:0] ENTRY = 32'h00001000;
    localparam logic [31:0] STK = 32'h0000F000;
    logic ref_clk, rst, reg_wr, reg_rd, imm_zext, exc_req, busy, irq, addr_err, mem_ack;
    logic [7:0] reg_addr, imm_in, exc_vector;
    logic [31:0] reg_wdata, reg_rdata, opr_a, opr_b, index_value, gbr_index_addr, stack_ptr, status_word;
    logic [31:0] gbr_value, vbr_value, mac_high, mac_low, return_addr, pc_value, imm_out, mem_rdata, d, sw;
    logic [3:0] rd_sel_a, rd_sel_b, slow;
    crs_wb_t wb;
    crs_ctl_t ctl_wr;
    crs_mac_t mac_wr;
    crs_acc_t acc;
    crs_mem_t mem_req;
    int fail_count = 0;
    int tests_run = 0;
    crs_core i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_sel_a(rd_sel_a), .rd_sel_b(rd_sel_b), .opr_a(opr_a),
        .opr_b(opr_b), .index_value(index_value), .gbr_index_addr(gbr_index_addr), .stack_ptr(stack_ptr),
        .status_word(status_word), .gbr_value(gbr_value), .vbr_value(vbr_value), .mac_high(mac_high),
        .mac_low(mac_low), .return_addr(return_addr), .pc_value(pc_value), .wb(wb), .ctl_wr(ctl_wr),
        .mac_wr(mac_wr), .imm_in(imm_in), .imm_zext(imm_zext), .imm_out(imm_out), .acc(acc),
        .addr_err(addr_err), .exc_req(exc_req), .exc_vector(exc_vector), .busy(busy), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
    crs_mem_model #(.BOOT_ENTRY(ENTRY), .BOOT_STACK(STK)) i_mem (.ref_clk(ref_clk), .rst(rst),
        .mem_req(mem_req), .slow(slow), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // strobes drop and an edge passes, so no signal is driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        step(1);
        reg_rd <= 1'b0;
        // read data settle after the strobe edge and stand for this cycle only
        #1 v = reg_rdata;
        step(1);
    endtask : rd
    task automatic put(input logic [3:0] r, input crs_wsrc_t s, input crs_size_t z, input logic [31:0] v);
        wb <= '{1'b1, r, s, z, v};
        step(1);
        wb.valid <= 1'b0;
        step(1);
    endtask : put
    task automatic ctl(input crs_creg_t s, input logic [31:0] v);
        ctl_wr <= '{1'b1, s, v};
        step(1);
        ctl_wr.valid <= 1'b0;
        step(1);
    endtask : ctl
    task automatic t_boot;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) step(1);
        chk(pc_value, ENTRY);
        chk(stack_ptr, STK);
        chk(vbr_value, CRS_VBR_RESET);
        chk(status_word & 32'h000000F0, 32'h000000F0);
        chk(status_word & ~CRS_SR_WMASK, 32'h00000000);
        rd(CRS_OFS_IRQ_STAT, d);
        chk(d, 32'h00000008);
        rd(CRS_OFS_IRQ_STAT, d);
        chk(d, 32'h00000000);
        $display("boot test done");
    endtask : t_boot
    task automatic t_regs;
        wr(CRS_OFS_GPR0 + 8'h0C, 32'hCAFE0003);
        wr(CRS_OFS_SR, 32'hFFFFFFFF);
        wr(CRS_OFS_PC, 32'h00000000);
        wr(CRS_OFS_VBR, 32'h00000100);
        rd(CRS_OFS_GPR0 + 8'h0C, d);
        chk(d, 32'hCAFE0003);
        rd(CRS_OFS_SR, d);
        chk(d, CRS_SR_WMASK);
        rd(CRS_OFS_PC, d);
        chk(d, ENTRY);
        rd(8'h7C, d);
        chk(d, 32'h00000000);
        step(8);
        chk(vbr_value, 32'h00000100);
        $display("register port test done");
    endtask : t_regs
    task automatic t_data;
        put(4'h0, CRS_WB_MEM, CRS_SZ_BYTE, 32'h12345680);
        chk(index_value, 32'hFFFFFF80);
        put(4'h0, CRS_WB_MEM, CRS_SZ_WORD, 32'h00008001);
        chk(index_value, 32'hFFFF8001);
        put(4'h0, CRS_WB_IMM_SEXT, CRS_SZ_BYTE, 32'h000000F0);
        chk(index_value, 32'hFFFFFFF0);
        put(4'h0, CRS_WB_IMM_ZEXT, CRS_SZ_BYTE, 32'hFFFFFFF0);
        chk(index_value, 32'h000000F0);
        put(4'h0, CRS_WB_MEM, CRS_SZ_LONG, 32'h89ABCDEF);
        chk(index_value, 32'h89ABCDEF);
        put(4'h7, CRS_WB_ALU, CRS_SZ_LONG, 32'h00000777);
        rd_sel_a <= 4'h7;
        rd_sel_b <= 4'h0;
        step(2);
        chk(opr_a, 32'h00000777);
        chk(opr_b, 32'h89ABCDEF);
        ctl(CRS_C_GBR, 32'h00010000);
        step(1);
        chk(gbr_index_addr, 32'h89ACCDEF);
        ctl(CRS_C_PR, 32'h00002222);
        chk(return_addr, 32'h00002222);
        mac_wr <= '{1'b1, 32'h0000ABCD, 32'h12340000};
        step(1);
        mac_wr.valid <= 1'b0;
        step(1);
        chk(mac_high, 32'h0000ABCD);
        chk(mac_low, 32'h12340000);
        for (int i = 0; i < 4; i++) begin
            imm_in <= i[1] ? 8'h7F : 8'h80;
            imm_zext <= i[0];
            step(2);
            chk({i[0] ? 24'h000000 : {24{~i[1]}}, imm_in}, imm_out);
        end
        $display("operand test done");
    endtask : t_data
    task automatic t_align;
        logic [7:0] c [7] = '{8'h03, 8'h91, 8'h12, 8'hA2, 8'h28, 8'hD4, 8'h6C};
        wr(CRS_OFS_IRQ_MASK, 32'h00000001);
        foreach (c[i]) begin
            acc <= '{1'b1, c[i][6], crs_size_t'(c[i][5:4]), {28'h0000100, c[i][3:0]}};
            step(1);
            acc.valid <= 1'b0;
            #1 chk({31'h0, addr_err}, {31'h0, c[i][7]});
            step(1);
        end
        step(2);
        chk({31'h0, irq}, 32'h00000001);
        wr(CRS_OFS_IRQ_MASK, 32'h00000000);
        step(1);
        chk({31'h0, irq}, 32'h00000000);
        rd(CRS_OFS_IRQ_STAT, d);
        chk(d, 32'h00000003);
        wr(CRS_OFS_IRQ_MASK, 32'h00000001);
        step(2);
        chk({31'h0, irq}, 32'h00000000);
        $display("alignment test done");
    endtask : t_align
    task automatic t_exc;
        put(4'hF, CRS_WB_ALU, CRS_SZ_LONG, 32'h0000E000);
        slow <= 4'h3;
        sw = status_word;
        exc_vector <= 8'h08;
        exc_req <= 1'b1;
        step(1);
        exc_req <= 1'b0;
        step(1);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) step(1);
        chk(stack_ptr, 32'h0000DFF8);
        chk(i_mem.wa[0], 32'h0000DFFC);
        chk(i_mem.wd[0], sw);
        chk(i_mem.wa[1], 32'h0000DFF8);
        chk(i_mem.wd[1], ENTRY);
        chk(pc_value, 32'hE0000120);
        rd(CRS_OFS_IRQ_STAT, d);
        chk(d & 32'h00000004, 32'h00000004);
        $display("exception test done");
    endtask : t_exc
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // the whole run is under two hundred cycles
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, imm_zext, exc_req} = '0;
        {reg_addr, reg_wdata, imm_in, exc_vector, rd_sel_a, rd_sel_b, slow} = '0;
        {wb, ctl_wr, mac_wr, acc} = '0;
        step(6);
        rst <= 1'b0;
        t_boot();
        t_regs();
        t_data();
        t_align();
        t_exc();
        stop_test();
    end
endmodule : crs_core_tb
